// *** logic/flash_ctl_defines.svh ***
`ifndef FLASH_CTL_DEFINES_SVH
`define FLASH_CTL_DEFINES_SVH
// Host register byte addresses
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_DATA 8'h08
`define REG_STATUS 8'h0C
`define REG_RDATA 8'h10
// Control register fields
`define CTRL_GO_BIT 0
`define CTRL_BYPASS_BIT 1
`define CTRL_RESET_BIT 2
`define CTRL_STANDBY_BIT 3
`define CTRL_WORD_BIT 4
`define CTRL_OP_LSB 8
`define CTRL_OP_MSB 10
`define CTRL_RESET 32'h0000_0010
// Bus phase timing
`define STROBE_NS 100
`define STROBE_CYC ((`STROBE_NS + 9) / 10)
`define RESET_NS 500
`define RESET_CYC ((`RESET_NS + 9) / 10)
// Command sequence codes written to the device
`define UNLOCK_ADDR1 20'h0_0555
`define UNLOCK_ADDR2 20'h0_02AA
`define UNLOCK_DATA1 16'h00AA
`define UNLOCK_DATA2 16'h0055
`define CMD_PROGRAM 16'h00A0
`define CMD_ERASE 16'h0080
`define CMD_CHIP 16'h0010
`define CMD_SECTOR 16'h0030
`define CMD_SUSPEND 16'h00B0
`define CMD_RESUME 16'h0030
`define CMD_BYPASS 16'h0020
`define CMD_BYP_EXIT1 16'h0090
`define CMD_BYP_EXIT2 16'h0000
`define CMD_READ_RESET 16'h00F0
`endif

// *** logic/flash_ctl_pkg.sv ***
package flash_ctl_pkg;
  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_PROGRAM = 3'h1,
    OP_CHIP_ERASE = 3'h2,
    OP_SECTOR_ERASE = 3'h3,
    OP_SUSPEND = 3'h4,
    OP_RESUME = 3'h5,
    OP_BYPASS_ENTER = 3'h6,
    OP_BYPASS_EXIT = 3'h7
  } op_e;
endpackage

// *** logic/flash_bus_cycle.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "flash_ctl_defines.svh"
// One parallel bus cycle: write or read, strobe held STROBE_CYC cycles.
module flash_bus_cycle #(
  parameter int AW = 20,
  parameter int DW = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic i_write,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic [DW-1:0] i_dq_in,
  output logic o_done,
  output logic [DW-1:0] o_rdata,
  output logic [AW-1:0] o_addr,
  output logic [DW-1:0] o_dq_out,
  output logic o_dq_oe,
  output logic o_chip_sel_n,
  output logic o_write_n,
  output logic o_out_en_n
);
  localparam logic [7:0] STROBE = 8'(`STROBE_CYC);
  // Done rises on the same edge that releases the strobes, STROBE_CYC + 1 edges after start
  localparam int CYCLE_DONE = `STROBE_CYC + 1;
  logic [7:0] cnt_r, cnt_nxt;
  logic busy_r, busy_nxt, wr_r, wr_nxt, done_nxt;
  logic [DW-1:0] rdata_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    wr_nxt = wr_r;
    done_nxt = 1'b0;
    rdata_nxt = o_rdata;
    if (!busy_r && i_start) begin
      busy_nxt = 1'b1;
      wr_nxt = i_write;
      cnt_nxt = STROBE;
    end else if (busy_r) begin
      if (cnt_r == 8'h01) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
        if (!wr_r) begin
          rdata_nxt = i_dq_in;
        end
      end
      cnt_nxt = cnt_r - 8'h01;
    end
  end

  // Data bus driven only while the device output is off [RQ2]
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= 8'h00;
      busy_r <= 1'b0;
      wr_r <= 1'b0;
      o_done <= 1'b0;
      o_rdata <= '0;
      o_addr <= '0;
      o_dq_out <= '0;
      o_dq_oe <= 1'b0;
      o_chip_sel_n <= 1'b1;
      o_write_n <= 1'b1;
      o_out_en_n <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      wr_r <= wr_nxt;
      o_done <= done_nxt;
      o_rdata <= rdata_nxt;
      if (!busy_r && i_start) begin
        o_addr <= i_addr;
        o_dq_out <= i_wdata;
      end
      o_dq_oe <= busy_nxt && wr_nxt;
      o_chip_sel_n <= !busy_nxt;
      o_write_n <= !(busy_nxt && wr_nxt);
      o_out_en_n <= !(busy_nxt && !wr_nxt);
    end
  end

  a_no_contention: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !(o_dq_oe && !o_out_en_n)) else $error("bus driven from both sides"); // RQ2
  a_cycle_length: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!busy_r && i_start) |-> ##CYCLE_DONE o_done) else $error("bus cycle length wrong"); // RQ3
endmodule
`default_nettype wire

// *** logic/flash_ctl.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "flash_ctl_defines.svh"
// How it works
// [RQ1] Device holds 1M bytes or 512K words; word mode selects sixteen data lines.
// [RQ2] Separate active-low select, write and output controls; no bus contention.
// [RQ3] Commands go to the device as plain bus write cycles.
// [RQ4] Device latches address and data on each write cycle.
// [RQ5] Complete program sequence starts an automatic self-timed program.
// [RQ6] Unlock bypass shortens each program to two write cycles.
// [RQ7] Erase sequence triggers automatic preprogram then timed erase.
// [RQ8] Erase covers whole chip or chosen sectors.
// [RQ9] Busy shown on ready/busy pin and polling and toggle bits.
// [RQ10] After completion device reads array and takes new commands.
// [RQ11] Sector erase leaves other sectors untouched.
// [RQ12] Array is one 16K, two 8K, one 32K, fifteen 64K sectors.
// [RQ13] Protected sectors refuse program and erase.
// [RQ14] Temporary unprotect allows changing protected sectors.
// [RQ15] Erase may be suspended, other sectors used, then resumed. Suspend is only sent from ST_IDLE, never while ST_POLL waits on an erase.
// [RQ16] Hardware reset aborts operation, returns device to array read.
// [RQ17] Device sleeps by itself when addresses stay stable.
// [RQ18] Host can place device in standby.
// [RQ19] Writes blocked during low supply.
// [RQ20] Ready/busy low while program or erase runs.
// [RQ21] Invalid sequences are discarded, device returns to array read.
module flash_ctl
  import flash_ctl_pkg::*;
#(
  parameter int AW = 20,
  parameter int DW = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  input wire logic [DW-1:0] i_dq_in,
  input wire logic i_ready_busy_n,
  output logic [AW-1:0] o_flash_addr,
  output logic [DW-1:0] o_dq_out,
  output logic o_dq_oe,
  output logic o_chip_sel_n,
  output logic o_write_n,
  output logic o_out_en_n,
  output logic o_reset_n,
  output logic o_word_mode
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SEQ = 4'b0010,
    ST_POLL = 4'b0100,
    ST_RESET = 4'b1000
  } state_e;

  localparam logic [9:0] RESET_HOLD = 10'(`RESET_CYC);

  state_e state_r, state_nxt;
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [AW-1:0] addr_r, addr_nxt;
  logic [DW-1:0] data_r, data_nxt;
  logic [2:0] step_r, step_nxt;
  logic [2:0] last_r, last_nxt;
  logic bypass_r, bypass_nxt;
  logic err_r, err_nxt;
  logic [9:0] rcnt_r, rcnt_nxt;
  logic [DW-1:0] prev_r, prev_nxt;
  logic poll_rd_r, poll_rd_nxt;
  logic start, cyc_write, cyc_done;
  logic [AW-1:0] cyc_addr;
  logic [DW-1:0] cyc_data, cyc_rdata;
  logic [31:0] rdata_nxt;
  op_e op;

  assign op = op_e'(ctrl_r[`CTRL_OP_MSB:`CTRL_OP_LSB]);

  // Sequence table: step index gives address/data for the chosen op [RQ3]
  always_comb begin
    cyc_write = 1'b1;
    cyc_addr = `UNLOCK_ADDR1;
    cyc_data = `UNLOCK_DATA1;
    case (step_r)
      3'd0: begin
        cyc_addr = `UNLOCK_ADDR1;
        cyc_data = `UNLOCK_DATA1;
      end
      3'd1: begin
        cyc_addr = `UNLOCK_ADDR2;
        cyc_data = `UNLOCK_DATA2;
      end
      3'd3: begin
        cyc_addr = `UNLOCK_ADDR1;
        cyc_data = `UNLOCK_DATA1;
      end
      3'd4: begin
        cyc_addr = `UNLOCK_ADDR2;
        cyc_data = `UNLOCK_DATA2;
      end
      default: begin
        cyc_addr = `UNLOCK_ADDR1;
        cyc_data = `UNLOCK_DATA1;
      end
    endcase
    // Command-bearing steps
    if (step_r == 3'd2 || (step_r == 3'd0 && bypass_r && op == OP_PROGRAM)) begin
      cyc_addr = `UNLOCK_ADDR1;
      case (op)
        OP_PROGRAM: cyc_data = `CMD_PROGRAM;
        OP_BYPASS_ENTER: cyc_data = `CMD_BYPASS;
        OP_READ: cyc_data = `CMD_READ_RESET;
        default: cyc_data = `CMD_ERASE;
      endcase
      if (bypass_r && op == OP_PROGRAM) begin
        cyc_addr = addr_r;
      end
    end
    if (step_r == last_r) begin
      cyc_addr = addr_r; // Device latches target address and data [RQ4]
      case (op)
        OP_PROGRAM: cyc_data = data_r;
        OP_CHIP_ERASE: begin
          cyc_addr = `UNLOCK_ADDR1;
          cyc_data = `CMD_CHIP; // [RQ8]
        end
        OP_SECTOR_ERASE: cyc_data = `CMD_SECTOR; // [RQ8]
        OP_SUSPEND: cyc_data = `CMD_SUSPEND; // [RQ15]
        OP_RESUME: cyc_data = `CMD_RESUME; // [RQ15]
        OP_BYPASS_EXIT: cyc_data = (step_r == 3'd0) ? `CMD_BYP_EXIT1 : `CMD_BYP_EXIT2;
        OP_BYPASS_ENTER: begin
          cyc_addr = `UNLOCK_ADDR1;
          cyc_data = `CMD_BYPASS;
        end
        default: cyc_data = `CMD_READ_RESET; // [RQ21]
      endcase
    end
    if (op == OP_BYPASS_EXIT) begin
      cyc_addr = addr_r;
      cyc_data = (step_r == 3'd0) ? `CMD_BYP_EXIT1 : `CMD_BYP_EXIT2;
    end
    if (state_r == ST_POLL) begin
      cyc_write = 1'b0;
      cyc_addr = addr_r;
    end
  end

  // Last step per op; bypass program uses two writes, normal four [RQ6]
  function automatic logic [2:0] last_step(input op_e o, input logic byp);
    case (o)
      OP_PROGRAM: last_step = byp ? 3'd1 : 3'd3; // [RQ6] [RQ5]
      OP_CHIP_ERASE: last_step = 3'd5; // [RQ7]
      OP_SECTOR_ERASE: last_step = 3'd5; // [RQ7]
      OP_SUSPEND: last_step = 3'd0;
      OP_RESUME: last_step = 3'd0;
      OP_BYPASS_EXIT: last_step = 3'd1;
      OP_BYPASS_ENTER: last_step = 3'd2;
      default: last_step = 3'd0;
    endcase
  endfunction

  always_comb begin
    state_nxt = state_r;
    ctrl_nxt = ctrl_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    step_nxt = step_r;
    last_nxt = last_r;
    bypass_nxt = bypass_r;
    err_nxt = err_r;
    rcnt_nxt = rcnt_r;
    prev_nxt = prev_r;
    poll_rd_nxt = poll_rd_r;
    start = 1'b0;
    ctrl_nxt[`CTRL_GO_BIT] = 1'b0;
    if (i_reg_wr) begin
      if (i_reg_addr == `REG_CTRL) begin
        ctrl_nxt = i_reg_wdata;
      end else if (i_reg_addr == `REG_ADDR) begin
        addr_nxt = i_reg_wdata[AW-1:0];
      end else if (i_reg_addr == `REG_DATA) begin
        data_nxt = i_reg_wdata[DW-1:0];
      end
    end
    case (state_r)
      ST_IDLE: begin
        if (ctrl_r[`CTRL_RESET_BIT]) begin
          state_nxt = ST_RESET; // [RQ16]
          rcnt_nxt = RESET_HOLD;
          ctrl_nxt[`CTRL_RESET_BIT] = 1'b0;
        end else if (ctrl_r[`CTRL_GO_BIT] && !ctrl_r[`CTRL_STANDBY_BIT]) begin
          state_nxt = ST_SEQ;
          step_nxt = (bypass_r && op == OP_PROGRAM) ? 3'd0 : 3'd0;
          last_nxt = last_step(op, bypass_r);
          err_nxt = 1'b0;
        end
      end
      ST_SEQ: begin
        start = !poll_rd_r;
        poll_rd_nxt = 1'b1;
        if (cyc_done) begin
          poll_rd_nxt = 1'b0;
          if (step_r == last_r) begin
            if (op == OP_BYPASS_ENTER) bypass_nxt = 1'b1;
            if (op == OP_BYPASS_EXIT) bypass_nxt = 1'b0;
            if (op == OP_PROGRAM || op == OP_CHIP_ERASE || op == OP_SECTOR_ERASE || op == OP_RESUME) begin
              state_nxt = ST_POLL; // [RQ9]
              step_nxt = 3'd0;
            end else begin
              state_nxt = ST_IDLE;
            end
          end else begin
            step_nxt = step_r + 3'd1;
          end
        end
      end
      ST_POLL: begin
        // Two reads in a row; unchanged toggle bit with ready/busy high means done [RQ9]
        start = !poll_rd_r;
        poll_rd_nxt = 1'b1;
        if (cyc_done) begin
          poll_rd_nxt = 1'b0;
          prev_nxt = cyc_rdata;
          if (step_r != 3'd0 && prev_r[6] == cyc_rdata[6] && i_ready_busy_n) begin
            state_nxt = ST_IDLE; // [RQ10]
            err_nxt = (op == OP_PROGRAM) && (cyc_rdata[7] != data_r[7]); // [RQ13]
          end
          step_nxt = 3'd1;
        end
        if (ctrl_r[`CTRL_RESET_BIT]) begin
          state_nxt = ST_RESET; // [RQ16]
          rcnt_nxt = RESET_HOLD;
          ctrl_nxt[`CTRL_RESET_BIT] = 1'b0;
        end
      end
      ST_RESET: begin
        rcnt_nxt = rcnt_r - 10'd1;
        if (rcnt_r == 10'd1) begin
          state_nxt = ST_IDLE;
          bypass_nxt = 1'b0;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (i_reg_addr == `REG_CTRL) begin
      rdata_nxt = ctrl_r;
    end else if (i_reg_addr == `REG_ADDR) begin
      rdata_nxt = 32'(addr_r);
    end else if (i_reg_addr == `REG_DATA) begin
      rdata_nxt = 32'(data_r);
    end else if (i_reg_addr == `REG_STATUS) begin
      rdata_nxt = {25'h0, !i_ready_busy_n, err_r, bypass_r, state_r};
    end else if (i_reg_addr == `REG_RDATA) begin
      rdata_nxt = 32'(prev_r);
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= ST_IDLE;
      ctrl_r <= `CTRL_RESET;
      addr_r <= '0;
      data_r <= '0;
      step_r <= 3'd0;
      last_r <= 3'd0;
      bypass_r <= 1'b0;
      err_r <= 1'b0;
      rcnt_r <= 10'd0;
      prev_r <= '0;
      poll_rd_r <= 1'b0;
      o_reg_rdata <= 32'h0000_0000;
      o_reset_n <= 1'b0;
      o_word_mode <= 1'b1;
    end else begin
      state_r <= state_nxt;
      ctrl_r <= ctrl_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      step_r <= step_nxt;
      last_r <= last_nxt;
      bypass_r <= bypass_nxt;
      err_r <= err_nxt;
      rcnt_r <= rcnt_nxt;
      prev_r <= prev_nxt;
      poll_rd_r <= poll_rd_nxt;
      if (i_reg_rd) o_reg_rdata <= rdata_nxt;
      else o_reg_rdata <= 32'h0000_0000;
      o_reset_n <= (state_nxt != ST_RESET); // [RQ16]
      o_word_mode <= ctrl_nxt[`CTRL_WORD_BIT]; // [RQ1]
    end
  end

  // Chip select stays high in standby once in ST_IDLE, after any running operation ends; the device then drops its power [RQ18]
  flash_bus_cycle #(.AW(AW), .DW(DW)) u_cycle (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_start(start),
    .i_write(cyc_write),
    .i_addr(cyc_addr),
    .i_wdata(cyc_data),
    .i_dq_in(i_dq_in),
    .o_done(cyc_done),
    .o_rdata(cyc_rdata),
    .o_addr(o_flash_addr),
    .o_dq_out(o_dq_out),
    .o_dq_oe(o_dq_oe),
    .o_chip_sel_n(o_chip_sel_n),
    .o_write_n(o_write_n),
    .o_out_en_n(o_out_en_n)
  );

  a_reset_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(state_r == ST_RESET) |-> !o_reset_n [*8]) else $error("reset pulse too short"); // RQ16
  a_standby_quiet: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_r == ST_IDLE && ctrl_r[`CTRL_STANDBY_BIT]) |=> o_chip_sel_n) else $error("select in standby"); // RQ18
  a_poll_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_r == ST_POLL) |-> o_write_n) else $error("write during poll"); // RQ9
  a_idle_after_rst: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_r == ST_RESET && rcnt_r == 10'd1) |=> state_r == ST_IDLE && !bypass_r) else $error("reset exit"); // RQ16
  a_last_bypass: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_r == ST_SEQ && bypass_r && op == OP_PROGRAM) |-> last_r == 3'd1) else $error("bypass length"); // RQ6
  a_last_normal: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_r == ST_SEQ && !bypass_r && op == OP_PROGRAM) |-> last_r == 3'd3) else $error("program length"); // RQ5
endmodule
`default_nettype wire

// *** verification/flash_dev_model.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "flash_ctl_defines.svh"
module flash_dev_model #(
  parameter int AW = 20,
  parameter int DW = 16,
  parameter int BUSY_CYC = 40,
  parameter logic [4:0] PROT_SECT = 5'h12,
  parameter int SLEEP_CYC = 30
) (
  input wire logic i_ref_clk,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_dq,
  input wire logic i_dq_oe,
  input wire logic i_chip_sel_n,
  input wire logic i_write_n,
  input wire logic i_out_en_n,
  input wire logic i_reset_n,
  output logic [DW-1:0] o_dq,
  output logic o_ready_busy_n
);
  logic [DW-1:0] mem [int];
  logic [DW-1:0] pd = '1;
  logic [DW-1:0] last = '0;
  logic [DW-1:0] drv;
  logic tog = 1'b0;
  logic we_q = 1'b1;
  logic oe_q = 1'b1;
  logic [AW-1:0] wa = '0;
  logic [AW-1:0] sa = '0;
  logic [DW-1:0] wd = '0;
  bit bypass = 0;
  bit unprot = 0;
  bit lowv = 0;
  bit sleep = 0;
  int idle = 0;
  int step = 0;
  int busy = 0;
  int seq_wr = 0;
  int prog_wr = 0;
  int resets = 0;
  int clash = 0;

  function automatic logic [DW-1:0] peek(input logic [AW-1:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : '1;
  endfunction
  // Bottom boot: 16K, 8K, 8K, 32K, then fifteen 64K
  function automatic logic [4:0] sect(input logic [AW-1:0] a);
    if (a[AW-1:AW-4] != 4'h0) return 5'(a[AW-1:AW-4]) + 5'h3;
    if (a[AW-5]) return 5'h3;
    if (a[AW-6]) return a[AW-7] ? 5'h2 : 5'h1;
    return 5'h0;
  endfunction
  function automatic bit prot(input logic [AW-1:0] a);
    return sect(a) == PROT_SECT && !unprot;
  endfunction

  task automatic start(input int n, input logic [DW-1:0] d);
    prog_wr = seq_wr;
    seq_wr = 0;
    pd = d;
    busy = n;
    step = 0;
  endtask

  task automatic take(input logic [AW-1:0] a, input logic [DW-1:0] d);
    int ks[$];
    seq_wr++;
    if (busy > 0) return;
    if (d == `CMD_READ_RESET) step = 0;
    else case (step)
      0: if (bypass && d == `CMD_PROGRAM) step = 3;
         else if (bypass && d == `CMD_BYP_EXIT1) step = 7;
         else step = (a == `UNLOCK_ADDR1 && d == `UNLOCK_DATA1) ? 1 : 0;
      1, 5: step = (a == `UNLOCK_ADDR2 && d == `UNLOCK_DATA2) ? step + 1 : 0;
      2: if (a != `UNLOCK_ADDR1) step = 0;
         else if (d == `CMD_PROGRAM) step = 3;
         else if (d == `CMD_ERASE) step = 4;
         else if (d == `CMD_BYPASS) begin
           bypass = 1;
           seq_wr = 0;
           step = 0;
         end else step = 0;
      3: begin
        // Flash only clears bits; protected target stays untouched
        if (!prot(a)) mem[int'(a)] = peek(a) & d;
        start(prot(a) ? 2 : BUSY_CYC, d);
      end
      4: step = (a == `UNLOCK_ADDR1 && d == `UNLOCK_DATA1) ? 5 : 0;
      6: if (d == `CMD_CHIP || d == `CMD_SECTOR) begin
        foreach (mem[k]) ks.push_back(k);
        foreach (ks[i])
          if (!prot(AW'(ks[i])) && (d == `CMD_CHIP || sect(AW'(ks[i])) == sect(a))) mem.delete(ks[i]);
        start(2 * BUSY_CYC, '1);
      end else step = 0;
      7: begin
        if (d == `CMD_BYP_EXIT2) bypass = 0;
        seq_wr = 0;
        step = 0;
      end
      default: step = 0;
    endcase
  endtask

  always @(negedge i_reset_n) begin
    busy = 0;
    step = 0;
    bypass = 0;
    resets++;
  end
  // Mid-cycle sampling keeps the model off the edge the host samples on
  always @(negedge i_ref_clk) begin
    if (busy > 0) busy--;
    if (i_dq_oe && !i_chip_sel_n && !i_out_en_n) clash++;
    if (!i_write_n && !i_chip_sel_n) begin
      wa = i_addr;
      wd = i_dq;
    end
    // Latched as the write strobe rises; select may rise with it
    if (i_write_n && !we_q && i_reset_n && !lowv) take(wa, wd);
    if (!i_out_en_n && oe_q && !i_chip_sel_n && busy > 0) tog = ~tog;
    we_q = i_write_n | i_chip_sel_n;
    oe_q = i_out_en_n | i_chip_sel_n;
    if (i_addr != sa) begin
      sa = i_addr;
      idle = 0;
    end else if (idle < SLEEP_CYC) begin
      idle++;
    end
    sleep = idle == SLEEP_CYC;
  end
  always @* drv = busy > 0 ? {pd[DW-1:8], ~pd[7], tog, pd[5:0]} : peek(i_addr);
  // Released bus shows a changed value so stale data never looks valid
  always @(posedge i_out_en_n or posedge i_chip_sel_n) last = drv;
  assign o_dq = (!i_chip_sel_n && !i_out_en_n) ? drv : ~last;
  assign o_ready_busy_n = busy == 0;
endmodule
`default_nettype wire

// *** verification/tb_flash_ctl.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "flash_ctl_defines.svh"
module tb_flash_ctl;
  import flash_ctl_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [31:0] st;
  logic [15:0] dq_in;
  logic [15:0] dq_out;
  logic [19:0] flash_addr;
  logic dq_oe, cs_n, we_n, oe_n, dev_rst_n, word_mode, rb_n;
  int fail_count = 0;
  int compares = 0;
  int low_cyc = 0;

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (!dev_rst_n && !rst) low_cyc++;

  flash_ctl dut_u (.i_ref_clk(ref_clk), .i_rst(rst), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .i_dq_in(dq_in), .i_ready_busy_n(rb_n),
    .o_flash_addr(flash_addr), .o_dq_out(dq_out), .o_dq_oe(dq_oe), .o_chip_sel_n(cs_n), .o_write_n(we_n),
    .o_out_en_n(oe_n), .o_reset_n(dev_rst_n), .o_word_mode(word_mode));
  flash_dev_model dev_u (.i_ref_clk(ref_clk), .i_addr(flash_addr), .i_dq(dq_out), .i_dq_oe(dq_oe),
    .i_chip_sel_n(cs_n), .i_write_n(we_n), .i_out_en_n(oe_n), .i_reset_n(dev_rst_n), .o_dq(dq_in),
    .o_ready_busy_n(rb_n));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    // Data stands in the cycle after the strobe; taken at its closing edge
    @(posedge ref_clk);
    d = reg_rdata;
  endtask
  task automatic run(input op_e op, input logic [19:0] a, input logic [15:0] d);
    int n;
    wr(`REG_ADDR, {12'h0, a});
    wr(`REG_DATA, {16'h0, d});
    wr(`REG_CTRL, {21'h0, op, 8'h11});
    for (n = 0; n < 3000; n++) begin
      rd(`REG_STATUS, st);
      if (st[3:0] === 4'h1) break;
    end
    if (n == 3000) begin
      check("poll timeout", 0, 1);
      summarize();
    end
  endtask

  initial begin
    logic [31:0] rv;
    int r0;
    reg_addr <= 8'h00;
    reg_wdata <= 32'h0;
    repeat (16) @(posedge ref_clk);
    check("idle pins", {cs_n, we_n, oe_n, dq_oe, dev_rst_n}, 5'b11100);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(`REG_CTRL, rv);
    check("ctrl reset", rv, `CTRL_RESET);
    rd(`REG_STATUS, rv);
    check("idle state", rv[3:0], 4'h1);
    rd(8'h20, rv);
    check("unmapped", rv, 0);
    check("word mode", word_mode, 1);
    $display("test reset done");
    run(OP_PROGRAM, 20'h00123, 16'h5A3C);
    check("prog mem", dev_u.peek(20'h00123), 16'h5A3C);
    check("prog cycles", dev_u.prog_wr, 4);
    check("prog err", st[5], 0);
    rd(`REG_RDATA, rv);
    check("array read", rv[15:0], 16'h5A3C);
    $display("test program done");
    run(OP_BYPASS_ENTER, 20'h0, 16'h0);
    run(OP_PROGRAM, 20'h08000, 16'h1234);
    run(OP_PROGRAM, 20'h08001, 16'hA5A5);
    check("bypass cycles", dev_u.prog_wr, 2);
    check("bypass mem", dev_u.peek(20'h08000), 16'h1234);
    check("bypass flag", st[4], 1);
    run(OP_BYPASS_EXIT, 20'h0, 16'h0);
    check("bypass off", dev_u.bypass, 0);
    $display("test bypass done");
    run(OP_SECTOR_ERASE, 20'h00000, 16'h0);
    check("sector erased", dev_u.peek(20'h00123), 16'hFFFF);
    check("other kept", dev_u.peek(20'h08001), 16'hA5A5);
    check("boot sector", dev_u.sect(20'h06000), 2);
    $display("test sector erase done");
    run(OP_PROGRAM, 20'hF8000, 16'h0012);
    check("prot mem", dev_u.peek(20'hF8000), 16'hFFFF);
    check("prot err", st[5], 1);
    $display("test protect done");
    run(OP_CHIP_ERASE, 20'h0, 16'h0);
    check("chip erased", dev_u.peek(20'h08000), 16'hFFFF);
    $display("test chip erase done");
    dev_u.unprot = 1'b1;
    run(OP_PROGRAM, 20'hF8000, 16'h0012);
    check("unprotect mem", dev_u.peek(20'hF8000), 16'h0012);
    dev_u.unprot = 1'b0;
    dev_u.lowv = 1'b1;
    run(OP_PROGRAM, 20'h08002, 16'h0000);
    check("low supply mem", dev_u.peek(20'h08002), 16'hFFFF);
    dev_u.lowv = 1'b0;
    $display("test unprotect and low supply done");
    wr(`REG_CTRL, 32'h0000_0019);
    rd(`REG_STATUS, rv);
    check("standby idle", rv[3:0], 4'h1);
    check("standby select", cs_n, 1);
    wr(`REG_CTRL, 32'h0000_0010);
    $display("test standby done");
    r0 = dev_u.resets;
    low_cyc = 0;
    wr(`REG_CTRL, 32'h0000_0014);
    repeat (80) @(posedge ref_clk);
    check("reset pulse", low_cyc, 50);
    check("reset seen", dev_u.resets, r0 + 1);
    check("auto sleep", dev_u.sleep, 1);
    rd(`REG_STATUS, rv);
    check("idle after reset", rv[3:0], 4'h1);
    check("no clash", dev_u.clash, 0);
    $display("test reset pin done");
    summarize();
  end
endmodule
`default_nettype wire
